// file: hdl/srv_device.sv
`timescale 1ns/1ns
`default_nettype none
module srv_device #(
    parameter logic [7:0] REFRESH_WRITES = srv_pkg::REFRESH_WRITES_RST,
    parameter logic [31:0] FW_VERSION = srv_pkg::FW_VERSION_RST
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link
    srv_link_if.dev link,
    // Status line pins
    input wire logic [7:0] status_line_n,
    // Radio events
    input wire logic pkt_delivered,
    input wire logic [7:0] pkt_strength,
    output logic ambient_req,
    input wire logic ambient_valid,
    input wire logic [7:0] ambient_sample,
    // Nonvolatile store
    input wire logic nv_write,
    output logic nv_refresh,
    // Indicator states
    input wire logic exception_flag,
    input wire logic tx_amp_active,
    input wire logic rx_amp_active,
    input wire logic near_full,
    input wire logic radio_transfer_active,
    input wire logic serial_buffer_empty
);
    // ----------------------------------------
    // Status line debounce
    // ----------------------------------------
    localparam logic [3:0] DEB_LAST = 4'(srv_pkg::DEBOUNCE_CYC - 1);
    logic [7:0] sync1_r;
    logic [7:0] sync2_r;
    logic [7:0] status_line_levels_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 8'h00;
            sync2_r <= 8'h00;
        end else begin
            sync1_r <= status_line_n;
            sync2_r <= sync1_r;
        end
    end
    // Each line takes a new level once it differs for DEBOUNCE_CYC cycles
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_deb
            logic [3:0] cnt_r;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt_r <= 4'h0;
                    status_line_levels_r[g] <= 1'b0;
                end else if (sync2_r[g] == status_line_levels_r[g]) begin
                    cnt_r <= 4'h0;
                end else if (cnt_r == DEB_LAST) begin
                    cnt_r <= 4'h0;
                    status_line_levels_r[g] <= sync2_r[g];
                end else begin
                    cnt_r <= cnt_r + 4'h1;
                end
            end
        end
    endgenerate
    // ----------------------------------------
    // Strength and refresh state
    // ----------------------------------------
    logic [7:0] last_strength_r;
    logic [7:0] write_cnt_r;
    logic [15:0] refresh_count_r;
    logic refresh_r;
    // Threshold clamped into the allowed window
    wire logic [7:0] refresh_at =
        (REFRESH_WRITES < 8'(srv_pkg::REFRESH_MIN_WRITES)) ?
        8'(srv_pkg::REFRESH_MIN_WRITES) :
        (REFRESH_WRITES > 8'(srv_pkg::REFRESH_MAX_WRITES)) ?
        8'(srv_pkg::REFRESH_MAX_WRITES) : REFRESH_WRITES;
    wire logic refresh_due = nv_write && (write_cnt_r + 8'h01 >= refresh_at);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_strength_r <= 8'h00;
            write_cnt_r <= 8'h00;
            refresh_count_r <= srv_pkg::REFRESH_COUNT_RST;
            refresh_r <= 1'b0;
        end else begin
            if (pkt_delivered) begin
                last_strength_r <= pkt_strength;
            end
            refresh_r <= refresh_due;
            if (refresh_due) begin
                write_cnt_r <= 8'h00;
                refresh_count_r <= refresh_count_r + 16'h0001;
            end else if (nv_write) begin
                write_cnt_r <= write_cnt_r + 8'h01;
            end
        end
    end
    assign nv_refresh = refresh_r;
    // ----------------------------------------
    // Read decode
    // ----------------------------------------
    wire logic [7:0] indicator_line_states = {2'b00,
        serial_buffer_empty, radio_transfer_active, near_full,
        rx_amp_active, tx_amp_active, exception_flag};
    function automatic logic [7:0] read_value(input logic [7:0] a,
                                              input logic [7:0] sl,
                                              input logic [7:0] ls,
                                              input logic [15:0] rc,
                                              input logic [7:0] ind);
        case (a)
            srv_pkg::ADDR_STATUS_LINES: read_value = sl;
            srv_pkg::ADDR_LAST_STRENGTH: read_value = ls;
            srv_pkg::ADDR_FW_MAJOR: read_value = FW_VERSION[31:24];
            srv_pkg::ADDR_FW_MINOR: read_value = FW_VERSION[23:16];
            srv_pkg::ADDR_FW_INCR: read_value = FW_VERSION[15:8];
            srv_pkg::ADDR_FW_SUFFIX: read_value = FW_VERSION[7:0];
            srv_pkg::ADDR_REFRESH_HIGH: read_value = rc[15:8];
            srv_pkg::ADDR_REFRESH_LOW: read_value = rc[7:0];
            srv_pkg::ADDR_INDICATORS: read_value = ind;
            default: read_value = 8'h00;
        endcase
    endfunction
    // ----------------------------------------
    // Command parser and reply
    // ----------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_SIZE = 4'b0001,
        ST_ESC1 = 4'b0010,
        ST_ESC2 = 4'b0011,
        ST_ADDR = 4'b0100,
        ST_WDATA = 4'b0101,
        ST_AMB = 4'b0110,
        ST_ACK = 4'b0111,
        ST_RADDR = 4'b1000,
        ST_RVAL = 4'b1001
    } srv_dev_state_e;
    srv_dev_state_e state_r;
    srv_dev_state_e state_nxt;
    logic long_r;
    logic [7:0] addr_r;
    logic [7:0] value_r;
    logic amb_req_r;
    wire logic [7:0] b = link.cmd_byte;
    wire logic v = link.cmd_valid;
    wire logic [7:0] full_addr = long_r ? (b | srv_pkg::HIGH_BIT) : b;
    wire logic is_ambient = full_addr == srv_pkg::ADDR_AMBIENT;
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: if (v && b == srv_pkg::HEADER) state_nxt = ST_SIZE;
            ST_SIZE: begin
                if (v) begin
                    state_nxt = (b == srv_pkg::SIZE_LOW ||
                                 b == srv_pkg::SIZE_HIGH) ? ST_ESC1 : ST_IDLE;
                end
            end
            ST_ESC1: begin
                if (v && b == srv_pkg::ESCAPE) begin
                    state_nxt = long_r ? ST_ESC2 : ST_ADDR;
                end else if (v) begin
                    state_nxt = ST_WDATA;
                end
            end
            ST_ESC2: begin
                if (v) begin
                    state_nxt = (b == srv_pkg::ESCAPE) ? ST_ADDR : ST_IDLE;
                end
            end
            ST_ADDR: if (v) state_nxt = is_ambient ? ST_AMB : ST_ACK;
            // Registers are read-only, the value is dropped
            ST_WDATA: if (v) state_nxt = ST_IDLE;
            ST_AMB: if (ambient_valid) state_nxt = ST_ACK;
            ST_ACK: state_nxt = ST_RADDR;
            ST_RADDR: state_nxt = ST_RVAL;
            ST_RVAL: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            long_r <= 1'b0;
            addr_r <= 8'h00;
            value_r <= 8'h00;
            amb_req_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            amb_req_r <= 1'b0;
            if (state_r == ST_SIZE && v) begin
                long_r <= b == srv_pkg::SIZE_HIGH;
            end
            if (state_r == ST_ADDR && v) begin
                addr_r <= full_addr;
                amb_req_r <= is_ambient;
                value_r <= read_value(full_addr, status_line_levels_r,
                    last_strength_r, refresh_count_r, indicator_line_states);
            end
            if (state_r == ST_AMB && ambient_valid) begin
                value_r <= ambient_sample;
            end
        end
    end
    assign ambient_req = amb_req_r;
    // Reply: acknowledge, full address, value
    assign link.rsp_valid = state_r == ST_ACK || state_r == ST_RADDR ||
                            state_r == ST_RVAL;
    assign link.rsp_byte = (state_r == ST_ACK) ? srv_pkg::ACK :
                           (state_r == ST_RADDR) ? addr_r :
                           (state_r == ST_RVAL) ? value_r : 8'h00;
endmodule
`default_nettype wire

// file: hdl/srv_pkg.sv
package srv_pkg;
    // ----------------------------------------
    // Framing bytes
    // ----------------------------------------
    localparam logic [7:0] HEADER = 8'hFF;
    localparam logic [7:0] SIZE_LOW = 8'h02;
    localparam logic [7:0] SIZE_HIGH = 8'h03;
    localparam logic [7:0] ESCAPE = 8'hFE;
    localparam logic [7:0] ACK = 8'h06;
    localparam logic [7:0] HIGH_BIT = 8'h80;
    // ----------------------------------------
    // Device register addresses
    // ----------------------------------------
    localparam logic [7:0] ADDR_STATUS_LINES = 8'h7A;
    localparam logic [7:0] ADDR_LAST_STRENGTH = 8'h7B;
    localparam logic [7:0] ADDR_AMBIENT = 8'h7C;
    localparam logic [7:0] ADDR_FW_MAJOR = 8'hC0;
    localparam logic [7:0] ADDR_FW_MINOR = 8'hC1;
    localparam logic [7:0] ADDR_FW_INCR = 8'hC2;
    localparam logic [7:0] ADDR_FW_SUFFIX = 8'hC3;
    localparam logic [7:0] ADDR_REFRESH_HIGH = 8'hC4;
    localparam logic [7:0] ADDR_REFRESH_LOW = 8'hC5;
    localparam logic [7:0] ADDR_INDICATORS = 8'hC6;
    // ----------------------------------------
    // Indicator byte fields
    // ----------------------------------------
    localparam int IND_EXCEPTION = 0;
    localparam int IND_TX_AMP = 1;
    localparam int IND_RX_AMP = 2;
    localparam int IND_NEAR_FULL = 3;
    localparam int IND_RADIO_XFER = 4;
    localparam int IND_SER_EMPTY = 5;
    localparam int IND_USED = 6;
    // ----------------------------------------
    // Device timing and counts
    // ----------------------------------------
    localparam int DEBOUNCE_NS = 1000;
    localparam int CLK_NS = 100;
    localparam int DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_NS - 1) / CLK_NS;
    localparam int REFRESH_MIN_WRITES = 8;
    localparam int REFRESH_MAX_WRITES = 150;
    localparam logic [7:0] REFRESH_WRITES_RST = 8'h40;
    localparam logic [15:0] REFRESH_COUNT_RST = 16'h0000;
    // Arbitrary firmware version value
    localparam logic [31:0] FW_VERSION_RST = 32'h0102_0300;
    // ----------------------------------------
    // Host APB map
    // ----------------------------------------
    localparam logic [7:0] APB_CMD = 8'h00;
    localparam logic [7:0] APB_RESULT = 8'h04;
    localparam logic [7:0] APB_INT_STATUS = 8'h08;
    localparam logic [7:0] APB_INT_MASK = 8'h0C;
    localparam int RES_BUSY = 16;
    localparam int RES_ERROR = 17;
    localparam int INT_DONE = 0;
    localparam int INT_ERROR = 1;
    localparam logic [1:0] INT_RST = 2'h0;
endpackage

// file: hdl/srv_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface srv_link_if;
    logic cmd_valid;
    logic [7:0] cmd_byte;
    logic rsp_valid;
    logic [7:0] rsp_byte;
    modport dev (input cmd_valid, input cmd_byte,
                 output rsp_valid, output rsp_byte);
    modport host (output cmd_valid, output cmd_byte,
                  input rsp_valid, input rsp_byte);
endinterface
`default_nettype wire

// file: hdl/srv_host.sv
`timescale 1ns/1ns
`default_nettype none
module srv_host (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt
    output logic irq,
    // Link
    srv_link_if.host link
);
    // ----------------------------------------
    // Register access
    // ----------------------------------------
    wire logic wr = psel && penable && pwrite;
    wire logic hit_cmd = paddr == srv_pkg::APB_CMD;
    wire logic hit_res = paddr == srv_pkg::APB_RESULT;
    wire logic hit_ist = paddr == srv_pkg::APB_INT_STATUS;
    wire logic hit_msk = paddr == srv_pkg::APB_INT_MASK;
    wire logic mapped = hit_cmd || hit_res || hit_ist || hit_msk;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SEND = 2'b01,
        ST_RECV = 2'b10
    } srv_host_state_e;
    srv_host_state_e state_r;
    logic [2:0] idx_r;
    logic [7:0] addr_r;
    logic [7:0] rsp_addr_r;
    logic [7:0] rsp_val_r;
    logic err_r;
    logic [1:0] ist_r;
    logic [1:0] msk_r;
    wire logic busy = state_r != ST_IDLE;
    // Long form escapes the high bit away
    wire logic long_form = addr_r[7];
    wire logic [2:0] last_idx = long_form ? 3'd4 : 3'd3;
    function automatic logic [7:0] cmd_at(input logic [2:0] i,
                                          input logic [7:0] a);
        case (i)
            3'd0: cmd_at = srv_pkg::HEADER;
            3'd1: cmd_at = a[7] ? srv_pkg::SIZE_HIGH : srv_pkg::SIZE_LOW;
            3'd2: cmd_at = srv_pkg::ESCAPE;
            3'd3: cmd_at = a[7] ? srv_pkg::ESCAPE : a;
            3'd4: cmd_at = {1'b0, a[6:0]};
            default: cmd_at = 8'h00;
        endcase
    endfunction
    wire logic start = wr && hit_cmd && !busy;
    wire logic rx = state_r == ST_RECV && link.rsp_valid;
    wire logic done = rx && idx_r == 3'd2;
    wire logic bad = (idx_r == 3'd0 && link.rsp_byte != srv_pkg::ACK) ||
                     (idx_r == 3'd1 && link.rsp_byte != addr_r);
    wire logic err_now = err_r || bad;
    // ----------------------------------------
    // Read sequencer
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            idx_r <= 3'd0;
            addr_r <= 8'h00;
            rsp_addr_r <= 8'h00;
            rsp_val_r <= 8'h00;
            err_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        addr_r <= pwdata[7:0];
                        idx_r <= 3'd0;
                        err_r <= 1'b0;
                        state_r <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (idx_r == last_idx) begin
                        idx_r <= 3'd0;
                        state_r <= ST_RECV;
                    end else begin
                        idx_r <= idx_r + 3'd1;
                    end
                end
                ST_RECV: begin
                    if (rx) begin
                        err_r <= err_now;
                        idx_r <= idx_r + 3'd1;
                        if (idx_r == 3'd1) rsp_addr_r <= link.rsp_byte;
                        if (done) begin
                            rsp_val_r <= link.rsp_byte;
                            state_r <= ST_IDLE;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end
    assign link.cmd_valid = state_r == ST_SEND;
    assign link.cmd_byte = (state_r == ST_SEND) ?
                           cmd_at(idx_r, addr_r) : 8'h00;
    // ----------------------------------------
    // Interrupt status and mask
    // ----------------------------------------
    wire logic [1:0] ev = {done && err_now, done && !err_now};
    wire logic [1:0] clr = (wr && hit_ist) ? pwdata[1:0] : 2'b00;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ist_r <= srv_pkg::INT_RST;
            msk_r <= srv_pkg::INT_RST;
        end else begin
            // A new event beats a clear in the same cycle
            ist_r <= (ist_r & ~clr) | ev;
            if (wr && hit_msk) msk_r <= pwdata[1:0];
        end
    end
    assign irq = |(ist_r & msk_r);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = hit_res ? {14'h0000, err_r, busy, rsp_addr_r, rsp_val_r} :
                    hit_ist ? {30'h0000_0000, ist_r} :
                    hit_msk ? {30'h0000_0000, msk_r} : 32'h0000_0000;
endmodule
`default_nettype wire

// file: bench/srv_link_checker.sv
`timescale 1ns/1ns
`default_nettype none
module srv_link_checker #(
    parameter logic [31:0] FW_VERSION = srv_pkg::FW_VERSION_RST
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_byte
);
    // ----------------------------------------
    // Command shapes
    // ----------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence low_pre;
        cmd_valid && cmd_byte == srv_pkg::HEADER ##1
        cmd_valid && cmd_byte == srv_pkg::SIZE_LOW ##1
        cmd_valid && cmd_byte == srv_pkg::ESCAPE;
    endsequence
    sequence hi_pre;
        cmd_valid && cmd_byte == srv_pkg::HEADER ##1
        cmd_valid && cmd_byte == srv_pkg::SIZE_HIGH ##1
        cmd_valid && cmd_byte == srv_pkg::ESCAPE ##1
        cmd_valid && cmd_byte == srv_pkg::ESCAPE;
    endsequence
    // ----------------------------------------
    // Reply framing
    // ----------------------------------------
    reply_ack_a: assert property (
        $rose(rsp_valid) |-> rsp_byte == srv_pkg::ACK)
        else $error("reply does not open with acknowledge");
    reply_len_a: assert property (
        $rose(rsp_valid) |-> rsp_valid [*3] ##1 !rsp_valid)
        else $error("reply is not three bytes");
    low_echo_a: assert property (
        low_pre ##1 cmd_valid && !cmd_byte[7] &&
        cmd_byte != srv_pkg::ADDR_AMBIENT |->
        ##1 rsp_valid && rsp_byte == srv_pkg::ACK
        ##1 rsp_byte == $past(cmd_byte, 2))
        else $error("low read reply address wrong");
    high_echo_a: assert property (
        hi_pre ##1 cmd_valid |-> ##1 rsp_valid
        ##1 rsp_byte == ($past(cmd_byte, 2) | srv_pkg::HIGH_BIT))
        else $error("high read reply address wrong");
    // ----------------------------------------
    // Reply values
    // ----------------------------------------
    ind_rsvd_a: assert property (
        hi_pre ##1 cmd_valid &&
        cmd_byte == (srv_pkg::ADDR_INDICATORS & ~srv_pkg::HIGH_BIT)
        |-> ##3 rsp_byte[7:6] == 2'b00)
        else $error("reserved indicator bits set");
    fw_major_a: assert property (
        hi_pre ##1 cmd_valid &&
        cmd_byte == (srv_pkg::ADDR_FW_MAJOR & ~srv_pkg::HIGH_BIT)
        |-> ##3 rsp_byte == FW_VERSION[31:24])
        else $error("version major byte wrong");
    fw_suffix_a: assert property (
        hi_pre ##1 cmd_valid &&
        cmd_byte == (srv_pkg::ADDR_FW_SUFFIX & ~srv_pkg::HIGH_BIT)
        |-> ##3 rsp_byte == FW_VERSION[7:0])
        else $error("version suffix byte wrong");
    // Reply must wait for a fresh sample
    ambient_wait_a: assert property (
        low_pre ##1 cmd_valid && cmd_byte == srv_pkg::ADDR_AMBIENT
        |-> ##1 !rsp_valid)
        else $error("ambient reply before sampling");
    no_overlap_a: assert property (rsp_valid |-> !cmd_valid)
        else $error("command sent during reply");
endmodule
`default_nettype wire

// file: bench/test_status_rssi_version_regs.sv
`timescale 1ns/1ns
`default_nettype none
module test_status_rssi_version_regs;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam logic [31:0] FW = 32'h0A0B_0C0D;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr, status_line_n, pkt_strength, ambient_sample, v;
    logic [31:0] pwdata, prdata, seed, rd, st;
    logic pkt_delivered, ambient_req, ambient_valid, nv_write, nv_refresh;
    logic [5:0] ind;
    logic [15:0] exp_q[$];
    int bad_count, samples_checked, refreshes;
    srv_link_if lk ();
    srv_device #(.REFRESH_WRITES(8'h08), .FW_VERSION(FW)) i_srv_device (
        .pclk(pclk), .presetn(presetn), .link(lk),
        .status_line_n(status_line_n), .pkt_delivered(pkt_delivered),
        .pkt_strength(pkt_strength), .ambient_req(ambient_req),
        .ambient_valid(ambient_valid), .ambient_sample(ambient_sample),
        .nv_write(nv_write), .nv_refresh(nv_refresh),
        .exception_flag(ind[0]), .tx_amp_active(ind[1]),
        .rx_amp_active(ind[2]), .near_full(ind[3]),
        .radio_transfer_active(ind[4]), .serial_buffer_empty(ind[5]));
    srv_host i_srv_host (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .link(lk));
    srv_link_checker #(.FW_VERSION(FW)) i_srv_link_checker (
        .pclk(pclk), .presetn(presetn), .cmd_valid(lk.cmd_valid),
        .cmd_byte(lk.cmd_byte), .rsp_valid(lk.rsp_valid),
        .rsp_byte(lk.rsp_byte));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return x[0] ? (x >> 1) ^ 32'h8020_0003 : x >> 1;
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        st = {31'h0000_0000, pslverr};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Result is checked here, the link reply by the monitor
    task automatic rd_link(input logic [7:0] a, input logic [7:0] e,
                           input logic clr);
        int n;
        n = 0;
        exp_q.push_back({a, e});
        apb(1'b1, srv_pkg::APB_CMD, {24'h00_0000, a});
        rd = 32'h0000_0000;
        while (rd[srv_pkg::INT_DONE] !== 1'b1 && n < 100) begin
            apb(1'b0, srv_pkg::APB_INT_STATUS, 32'h0000_0000);
            n++;
        end
        check({31'h0000_0000, rd[srv_pkg::INT_DONE]}, 32'h0000_0001);
        apb(1'b0, srv_pkg::APB_RESULT, 32'h0000_0000);
        check(rd & 32'h0003_FFFF, {16'h0000, a, e});
        if (clr) apb(1'b1, srv_pkg::APB_INT_STATUS, 32'h0000_0003);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // Clock, far-side responders, monitor
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        ambient_valid = 1'b0;
        ambient_sample = 8'h00;
        forever begin
            @(posedge pclk);
            if (ambient_req === 1'b1) begin
                ambient_valid <= 1'b1;
                ambient_sample <= 8'hA4;
                @(posedge pclk);
                ambient_valid <= 1'b0;
                ambient_sample <= 8'h5B;
            end
        end
    end
    always @(negedge pclk) if (nv_refresh === 1'b1) refreshes++;
    initial begin
        logic [23:0] b;
        forever begin
            @(negedge pclk);
            if (lk.rsp_valid === 1'b1) begin
                b[23:16] = lk.rsp_byte;
                @(negedge pclk);
                b[15:8] = lk.rsp_byte;
                @(negedge pclk);
                b[7:0] = lk.rsp_byte;
                if (exp_q.size() == 0) check({8'h00, b}, 32'h0000_0000);
                else check({8'h00, b},
                    {8'h00, srv_pkg::ACK, exp_q.pop_front()});
            end
        end
    end
    // Bound well above the longest expected run
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        print_verdict();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, pkt_delivered, nv_write} = 6'h00;
        {paddr, status_line_n, pkt_strength, ind} = 30'h0000_0000;
        pwdata = 32'h0000_0000;
        seed = 32'h0000_492E;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            status_line_n <= seed[7:0];
            repeat (20) @(posedge pclk);
            rd_link(srv_pkg::ADDR_STATUS_LINES, seed[7:0], 1'b1);
        end
        $display("status line test done");
        for (int i = 0; i < 2; i++) begin
            v = i ? 8'h80 : 8'hB5;
            pkt_strength <= v;
            pkt_delivered <= 1'b1;
            @(posedge pclk);
            pkt_delivered <= 1'b0;
            pkt_strength <= 8'h10;
            rd_link(srv_pkg::ADDR_LAST_STRENGTH, v, 1'b1);
        end
        rd_link(srv_pkg::ADDR_AMBIENT, 8'hA4, 1'b1);
        $display("strength test done");
        for (int i = 0; i < 4; i++)
            rd_link(srv_pkg::ADDR_FW_MAJOR | 8'(i),
                FW[31 - 8 * i -: 8], 1'b1);
        $display("version test done");
        repeat (29) begin
            @(posedge pclk);
            // Pulse nv_write high for one cycle in every two, 29 writes in all
            nv_write <= 1'b1;
            @(posedge pclk);
            nv_write <= 1'b0;
        end
        rd_link(srv_pkg::ADDR_REFRESH_HIGH, 8'h00, 1'b1);
        rd_link(srv_pkg::ADDR_REFRESH_LOW, 8'h03, 1'b1);
        check(refreshes, 32'h0000_0003);
        $display("refresh test done");
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            v = (i == 3) ? 8'h3F : {2'b00, seed[5:0]};
            ind <= v[5:0];
            rd_link(srv_pkg::ADDR_INDICATORS, v, 1'b1);
        end
        $display("indicator test done");
        rd_link(8'h10, 8'h00, 1'b1);
        apb(1'b0, 8'h20, 32'h0000_0000);
        check(st, 32'h0000_0001);
        check(rd, 32'h0000_0000);
        apb(1'b1, srv_pkg::APB_INT_MASK, 32'h0000_0001);
        rd_link(srv_pkg::ADDR_STATUS_LINES, status_line_n, 1'b0);
        @(negedge pclk);
        check({31'h0000_0000, irq}, 32'h0000_0001);
        apb(1'b1, srv_pkg::APB_INT_MASK, 32'h0000_0000);
        @(negedge pclk);
        check({31'h0000_0000, irq}, 32'h0000_0000);
        apb(1'b1, srv_pkg::APB_INT_MASK, 32'h0000_0001);
        apb(1'b1, srv_pkg::APB_INT_STATUS, 32'h0000_0001);
        @(negedge pclk);
        check({31'h0000_0000, irq}, 32'h0000_0000);
        $display("bus and interrupt test done");
        print_verdict();
    end
endmodule
`default_nettype wire
